// ---- inc/cts_consts.vh ----
`ifndef CTS_CONSTS_VH
`define CTS_CONSTS_VH
// time base
`define CTS_CLK_MHZ 100
`define CTS_US_PER_SEC 1000000
`define CTS_US_PER_MS 1000
`define CTS_SEC_PER_HOUR 3600
`define CTS_SEC_PER_MIN 60
// timer figures
`define CTS_INT_PULSE_US 256
`define CTS_HIC_OFF_MS 32
`define CTS_HIC_ON_US 260
`define CTS_USB_MIN 45
`define CTS_PRE_HOURS 4
`define CTS_FAST_H0 5
`define CTS_FAST_H1 8
`define CTS_FAST_H2 12
`define CTS_FAST_H3 20
`define CTS_TMR_DEF 2'h2
// charge phase codes
`define CTS_PH_OFF 2'h0
`define CTS_PH_PRE 2'h1
`define CTS_PH_FAST 2'h2
`define CTS_PH_DONE 2'h3
// fault category codes
`define CTS_FLT_NONE 2'h0
`define CTS_FLT_INPUT 2'h1
`define CTS_FLT_THERM 2'h2
`define CTS_FLT_TIMER 2'h3
// charge configuration codes
`define CTS_CFG_OFF 2'h0
`define CTS_CFG_CHG 2'h1
// hiccup states
`define CTS_HIC_RUN 2'h0
`define CTS_HIC_OFF 2'h1
`define CTS_HIC_TRY 2'h2
// synchronised input count
`define CTS_NSYNC 19
`endif

// ---- logic/cts_top.v ----
// Operation
// - end charge at voltage above recharge and current below termination; open battery switch.
// - on termination show phase done and pulse interrupt.
// - no termination during input or thermal regulation.
// - termination enable bit low disables automatic termination.
// - four hour limit while battery below low-battery threshold.
// - two-bit fast timer duration field, twelve hours after reset.
// - timer expiry sets fault category timer code and pulses interrupt.
// - timer enable bit low keeps the safety timer inactive.
// - after expiry restart on enable pin toggle, config 00 to 01, enable rise.
// - timer half rate in input regulation, thermal regulation or reduced current.
// - half-rate control bit low keeps the timer at full rate.
// - default mode 100 mA source: 45 minute cap, then stop and high impedance.
// - status pin low while charging, released when done, asleep or disabled.
// - 256 us interrupt pulse on source, good input, removal, done, fault.
// - non-fault events always pulse; faults pulse and latch until read.
// - pending fault blocks new fault pulses except thermistor and input overvoltage; thermistor field live.
// - first fault read returns latched state, second read live state.
// - thermal regulation reduces current and sets status bit; limit field selects.
// - thermal shutdown stops converter, sets thermal code, pulses interrupt.
// - input overvoltage stops switching, sets input code, pulses interrupt.
// - boost overcurrent hiccup: switch off 32 ms, on 260 us, until cleared.
// - boost overcurrent or overvoltage sets boost fault; overvoltage exits boost.
// - phase codes 00 off, 01 precharge, 10 fast, 11 done.
`timescale 1ns/1ps
`include "cts_consts.vh"
module cts_top #(
  parameter [26:0] SEC_CYCLES = `CTS_CLK_MHZ * `CTS_US_PER_SEC,
  parameter [14:0] INT_CYCLES = `CTS_INT_PULSE_US * `CTS_CLK_MHZ,
  parameter [21:0] HIC_OFF_CYCLES = `CTS_HIC_OFF_MS * `CTS_US_PER_MS * `CTS_CLK_MHZ,
  parameter [21:0] HIC_ON_CYCLES = `CTS_HIC_ON_US * `CTS_CLK_MHZ,
  parameter [16:0] PRE_SEC = `CTS_PRE_HOURS * `CTS_SEC_PER_HOUR,
  parameter [16:0] FAST_SEC0 = `CTS_FAST_H0 * `CTS_SEC_PER_HOUR,
  parameter [16:0] FAST_SEC1 = `CTS_FAST_H1 * `CTS_SEC_PER_HOUR,
  parameter [16:0] FAST_SEC2 = `CTS_FAST_H2 * `CTS_SEC_PER_HOUR,
  parameter [16:0] FAST_SEC3 = `CTS_FAST_H3 * `CTS_SEC_PER_HOUR,
  parameter [11:0] USB_SEC = `CTS_USB_MIN * `CTS_SEC_PER_MIN
) (
  input wire sys_clk, // 100 MHz
  input wire rst, // sync, high
  input wire clk_en, // freezes all state
  input wire charge_en_pin_n, // enable pin, low enables
  input wire batt_above_recharge, // comparator
  input wire chg_below_term, // comparator
  input wire batt_below_lowbat, // comparator
  input wire input_current_regulation, // loop flag
  input wire input_voltage_regulation, // loop flag
  input wire thermal_regulation, // loop flag
  input wire thermal_shutdown, // comparator
  input wire input_overvoltage, // comparator
  input wire system_overvoltage, // comparator
  input wire boost_overcurrent, // comparator
  input wire boost_overvoltage, // comparator
  input wire source_identified, // detection done
  input wire good_input, // input qualified
  input wire usb100_source, // 100 mA host seen
  input wire [2:0] ntc_fault_in, // thermistor state
  input wire sleep_mode, // input below battery
  input wire default_mode, // no host control
  input wire term_enable, // termination enable
  input wire timer_enable, // safety timer enable
  input wire timer_dur_we, // duration write strobe
  input wire [1:0] timer_dur_wdata, // duration write data
  input wire [1:0] charge_config, // charge config field
  input wire reduced_current_bit, // reduced current
  input wire half_rate_enable, // half-rate control
  input wire [1:0] thermal_limit_sel, // thermal limit field
  input wire fault_rd, // fault register read
  output reg [7:0] fault_rd_data, // fault register value
  output wire [1:0] charge_phase, // phase status field
  output reg thermal_reg_status, // thermal reg status bit
  output reg [1:0] thermal_limit_out, // to thermal loop
  output reg [1:0] timer_dur_reg, // duration field
  output reg battery_switch_off, // battery switch open
  output reg converter_off, // stop switching
  output reg boost_exit, // leave boost mode
  output reg input_high_impedance, // input in high-z
  output reg reverse_block_switch_on, // hiccup switch
  output reg int_pulse_n, // interrupt, low pulse
  output wire stat_o, // status pin level
  output reg stat_oe // status pin enable
);
  localparam [1:0] ST_OFF = `CTS_PH_OFF, ST_PRE = `CTS_PH_PRE;
  localparam [1:0] ST_FAST = `CTS_PH_FAST, ST_DONE = `CTS_PH_DONE;
  reg [`CTS_NSYNC-1:0] s1_reg, s2_reg, s3_reg, f_reg, fd_reg;
  wire [`CTS_NSYNC-1:0] raw;
  wire [`CTS_NSYNC-1:0] f_next;
  // pin inputs: three flops, filtered value sets once stages two and three are both high, clears when they differ
  assign raw = {sleep_mode, ntc_fault_in, usb100_source, good_input, source_identified,
                boost_overvoltage, boost_overcurrent, system_overvoltage,
                input_overvoltage, thermal_shutdown, thermal_regulation,
                input_voltage_regulation, input_current_regulation, batt_below_lowbat,
                chg_below_term, batt_above_recharge, charge_en_pin_n};
  assign f_next = (s2_reg & s3_reg) | (f_reg & ~(s2_reg ^ s3_reg));
  always @(posedge sys_clk) begin
    if (rst) begin
      s1_reg <= {`CTS_NSYNC{1'b0}};
      s2_reg <= {`CTS_NSYNC{1'b0}};
      s3_reg <= {`CTS_NSYNC{1'b0}};
      f_reg <= {`CTS_NSYNC{1'b0}};
      fd_reg <= {`CTS_NSYNC{1'b0}};
    end else if (clk_en) begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      f_reg <= f_next;
      fd_reg <= f_reg;
    end
  end
  wire ce_n = f_reg[0], above_rch = f_reg[1];
  wire below_term = f_reg[2], below_low = f_reg[3];
  wire in_reg = f_reg[4] | f_reg[5];
  wire therm_reg = f_reg[6];
  wire tsd = f_reg[7], in_ovp = f_reg[8];
  wire sys_ovp = f_reg[9];
  wire b_oc = f_reg[10];
  wire b_ov = f_reg[11];
  wire [2:0] ntc = f_reg[17:15];
  wire sleep = f_reg[18];
  wire src_rise = f_reg[12] & ~fd_reg[12];
  wire good_rise = f_reg[13] & ~fd_reg[13];
  wire good_fall = ~f_reg[13] & fd_reg[13];
  wire usb100 = f_reg[14];
  wire ovp_rise = in_ovp & ~fd_reg[8];
  wire ce_rise = ce_n & ~fd_reg[0];
  // one-second time base shared by all long timers
  reg [26:0] pre_reg;
  reg half_ph_reg;
  wire sec_tick = (pre_reg == SEC_CYCLES - 27'h1);
  wire half_mode = half_rate_enable & (in_reg | therm_reg | reduced_current_bit);
  wire safety_tick = sec_tick & (~half_mode | half_ph_reg);
  always @(posedge sys_clk) begin
    if (rst) begin
      pre_reg <= 27'h0;
      half_ph_reg <= 1'b0;
    end else if (clk_en) begin
      pre_reg <= sec_tick ? 27'h0 : pre_reg + 27'h1;
      if (sec_tick)
        half_ph_reg <= ~half_ph_reg;
    end
  end
  reg [1:0] st_reg, st_next;
  reg [16:0] tmr_reg;
  reg [16:0] fast_lim;
  reg expired_reg, usb_hiz_reg, ten_d_reg;
  reg [1:0] cfg_d_reg;
  reg [11:0] usb_cnt_reg;
  wire charging = (st_reg == ST_PRE) | (st_reg == ST_FAST);
  // ntc and shutdown block charging; an expired timer keeps it off until restarted
  wire allowed = (charge_config == `CTS_CFG_CHG) & ~ce_n & ~expired_reg & ~(|ntc) &
                 ~usb_hiz_reg & ~tsd & ~in_ovp & ~sleep;
  wire term_ok = term_enable & above_rch & below_term & ~in_reg & ~therm_reg;
  wire [16:0] lim = (st_reg == ST_PRE) ? PRE_SEC : fast_lim;
  wire timer_hit = charging & timer_enable & (tmr_reg >= lim);
  wire restart = ce_rise | (cfg_d_reg == `CTS_CFG_OFF & charge_config == `CTS_CFG_CHG) |
                 (timer_enable & ~ten_d_reg);
  wire done_evt = (st_reg == ST_FAST) & (st_next == ST_DONE);
  assign charge_phase = st_reg;
  // duration select
  always @* begin
    case (timer_dur_reg)
      2'h0: fast_lim = FAST_SEC0;
      2'h1: fast_lim = FAST_SEC1;
      2'h2: fast_lim = FAST_SEC2;
      default: fast_lim = FAST_SEC3;
    endcase
  end
  // charge phase sequencing
  always @* begin
    st_next = st_reg;
    case (st_reg)
      ST_OFF: begin
        if (allowed)
          st_next = below_low ? ST_PRE : ST_FAST;
      end
      ST_PRE: begin
        if (~allowed | timer_hit)
          st_next = ST_OFF;
        else if (~below_low)
          st_next = ST_FAST;
      end
      ST_FAST: begin
        if (~allowed | timer_hit)
          st_next = ST_OFF;
        else if (term_ok)
          st_next = ST_DONE;
      end
      ST_DONE: begin
        if (~allowed)
          st_next = ST_OFF;
        else if (~above_rch)
          st_next = ST_FAST;
      end
      default: st_next = ST_OFF;
    endcase
  end
  // safety timer, expiry flag, usb timer
  always @(posedge sys_clk) begin
    if (rst) begin
      st_reg <= ST_OFF;
      tmr_reg <= 17'h0;
      expired_reg <= 1'b0;
      timer_dur_reg <= `CTS_TMR_DEF;
      cfg_d_reg <= `CTS_CFG_OFF;
      ten_d_reg <= 1'b0;
      usb_cnt_reg <= 12'h0;
      usb_hiz_reg <= 1'b0;
    end else if (clk_en) begin
      st_reg <= st_next;
      cfg_d_reg <= charge_config;
      ten_d_reg <= timer_enable;
      if (timer_dur_we)
        timer_dur_reg <= timer_dur_wdata;
      if (~charging | ~timer_enable)
        tmr_reg <= 17'h0;
      else if (safety_tick)
        tmr_reg <= tmr_reg + 17'h1;
      // expiry wins over a restart in the same cycle
      if (timer_hit)
        expired_reg <= 1'b1;
      else if (restart)
        expired_reg <= 1'b0;
      if (~(default_mode & usb100 & charging))
        usb_cnt_reg <= 12'h0;
      else if (sec_tick & (usb_cnt_reg != USB_SEC))
        usb_cnt_reg <= usb_cnt_reg + 12'h1;
      // a removed source lets default mode leave high-z; host mode stays
      if (default_mode & usb100 & charging & (usb_cnt_reg == USB_SEC))
        usb_hiz_reg <= 1'b1;
      else if (default_mode & ~usb100)
        usb_hiz_reg <= 1'b0;
    end
  end
  // boost hiccup sequence
  reg [1:0] hic_reg, hic_next;
  reg [21:0] hic_cnt_reg;
  wire off_end = (hic_cnt_reg == HIC_OFF_CYCLES - 22'h1);
  wire on_end = (hic_cnt_reg == HIC_ON_CYCLES - 22'h1);
  always @* begin
    hic_next = hic_reg;
    case (hic_reg)
      `CTS_HIC_RUN: begin
        if (b_oc)
          hic_next = `CTS_HIC_OFF;
      end
      `CTS_HIC_OFF: begin
        if (off_end)
          hic_next = `CTS_HIC_TRY;
      end
      `CTS_HIC_TRY: begin
        if (on_end)
          hic_next = b_oc ? `CTS_HIC_OFF : `CTS_HIC_RUN;
      end
      default: hic_next = `CTS_HIC_RUN;
    endcase
  end
  always @(posedge sys_clk) begin
    if (rst) begin
      hic_reg <= `CTS_HIC_RUN;
      hic_cnt_reg <= 22'h0;
      reverse_block_switch_on <= 1'b1;
    end else if (clk_en) begin
      hic_reg <= hic_next;
      hic_cnt_reg <= (hic_next != hic_reg) ? 22'h0 : hic_cnt_reg + 22'h1;
      reverse_block_switch_on <= (hic_next != `CTS_HIC_OFF);
    end
  end
  // fault latch: shutdown outranks input overvoltage outranks expiry
  reg [1:0] lat_cat_reg, cat_d_reg;
  reg lat_boost_reg, boost_d_reg;
  reg [2:0] ntc_d_reg;
  wire [1:0] cat_live = tsd ? `CTS_FLT_THERM : in_ovp ? `CTS_FLT_INPUT :
                        expired_reg ? `CTS_FLT_TIMER : `CTS_FLT_NONE;
  wire boost_live = b_oc | b_ov;
  wire flt_evt = (boost_live & ~boost_d_reg) |
                 ((cat_live != `CTS_FLT_NONE) & (cat_live != cat_d_reg));
  wire pending = lat_boost_reg | (lat_cat_reg != `CTS_FLT_NONE);
  wire ntc_evt = (ntc != ntc_d_reg) & (|ntc);
  always @(posedge sys_clk) begin
    if (rst) begin
      lat_cat_reg <= `CTS_FLT_NONE;
      lat_boost_reg <= 1'b0;
      cat_d_reg <= `CTS_FLT_NONE;
      boost_d_reg <= 1'b0;
      ntc_d_reg <= 3'h0;
      fault_rd_data <= 8'h0;
    end else if (clk_en) begin
      cat_d_reg <= cat_live;
      boost_d_reg <= boost_live;
      ntc_d_reg <= ntc;
      if (fault_rd)
        fault_rd_data <= {default_mode, lat_boost_reg, lat_cat_reg, 1'b0, ntc};
      // a read reloads from live state, so a fault arriving with the read survives
      if (fault_rd) begin
        lat_cat_reg <= cat_live;
        lat_boost_reg <= boost_live;
      end else if (flt_evt & ~pending) begin
        lat_cat_reg <= cat_live;
        lat_boost_reg <= boost_live;
      end
    end
  end
  // interrupt pulse, retriggered by any new event
  reg [14:0] int_cnt_reg;
  wire int_trig = src_rise | good_rise | good_fall | ovp_rise | done_evt |
                  (flt_evt & ~pending) | ntc_evt;
  wire [14:0] int_cnt_next = int_trig ? INT_CYCLES :
                             (int_cnt_reg != 15'h0) ? int_cnt_reg - 15'h1 : 15'h0;
  always @(posedge sys_clk) begin
    if (rst) begin
      int_cnt_reg <= 15'h0;
      int_pulse_n <= 1'b1;
    end else if (clk_en) begin
      int_cnt_reg <= int_cnt_next;
      int_pulse_n <= (int_cnt_next == 15'h0);
    end
  end
  // power stage and pin outputs
  assign stat_o = 1'b0;
  always @(posedge sys_clk) begin
    if (rst) begin
      battery_switch_off <= 1'b0;
      converter_off <= 1'b0;
      boost_exit <= 1'b0;
      input_high_impedance <= 1'b0;
      thermal_reg_status <= 1'b0;
      thermal_limit_out <= 2'h0;
      stat_oe <= 1'b0;
    end else if (clk_en) begin
      battery_switch_off <= (st_next == ST_DONE);
      converter_off <= tsd | in_ovp | sys_ovp | usb_hiz_reg | b_ov;
      boost_exit <= b_ov;
      input_high_impedance <= usb_hiz_reg;
      thermal_reg_status <= therm_reg;
      thermal_limit_out <= thermal_limit_sel;
      stat_oe <= (st_next == ST_PRE) | (st_next == ST_FAST);
    end
  end
endmodule

// ---- tb/cts_top_assertions.sv ----
`timescale 1ns/1ps
module cts_top_assertions (
  input wire sys_clk, // clock
  input wire rst, // sync reset
  input wire clk_en, // run enable
  input wire timer_dur_we, // duration strobe
  input wire [1:0] timer_dur_wdata, // duration data
  input wire [1:0] charge_phase, // phase field
  input wire [1:0] timer_dur_reg, // duration field
  input wire battery_switch_off, // switch open
  input wire converter_off, // stop switching
  input wire input_high_impedance, // input high-z
  input wire reverse_block_switch_on, // hiccup switch
  input wire int_pulse_n, // interrupt
  input wire stat_o, // status level
  input wire stat_oe // status enable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire chg = (charge_phase == 2'h1) || (charge_phase == 2'h2);
  // pulse and hiccup windows are shortened in the bench to 8, 10 and 4 cycles
  sequence int_low_s; !int_pulse_n [*8]; endsequence
  sequence sw_off_s; !reverse_block_switch_on [*8]; endsequence
  sequence sw_on_s; reverse_block_switch_on [*4]; endsequence
  sequence to_done_s; $past(charge_phase) == 2'h2 && charge_phase == 2'h3; endsequence
  int_len_a: assert property ($fell(int_pulse_n) |-> int_low_s)
    else $error("interrupt pulse too short");
  sw_off_a: assert property ($fell(reverse_block_switch_on) |-> sw_off_s)
    else $error("hiccup off window too short");
  sw_on_a: assert property ($rose(reverse_block_switch_on) |-> sw_on_s)
    else $error("hiccup on window too short");
  done_int_a: assert property (to_done_s |-> ##[0:1] !int_pulse_n)
    else $error("no interrupt on charge done");
  done_switch_a: assert property (to_done_s |-> ##[0:1] battery_switch_off)
    else $error("battery switch not opened on done");
  stat_chg_a: assert property (chg && $stable(charge_phase) |-> stat_oe && !stat_o)
    else $error("status pin not low while charging");
  stat_idle_a: assert property (!chg && $stable(charge_phase) |-> !stat_oe)
    else $error("status pin driven while not charging");
  dur_write_a: assert property (timer_dur_we && clk_en |=> timer_dur_reg == $past(timer_dur_wdata))
    else $error("duration write lost");
  dur_hold_a: assert property (!timer_dur_we |=> $stable(timer_dur_reg))
    else $error("duration field changed without write");
  hiz_stop_a: assert property (input_high_impedance |-> converter_off)
    else $error("high impedance without converter stop");
endmodule

// ---- tb/cts_host_model.sv ----
`timescale 1ns/1ps
module cts_host_model (
  input wire sys_clk, // clock
  input wire [7:0] fault_rd_data, // fault register value
  output reg fault_rd, // read strobe
  output reg timer_dur_we, // write strobe
  output reg [1:0] timer_dur_wdata // write data
);
  initial begin
    fault_rd = 1'b0;
    timer_dur_we = 1'b0;
    timer_dur_wdata = 2'h0;
  end
  // one-cycle strobe; value taken after the answering edge has landed
  task rd(output [7:0] d);
    begin
      @(negedge sys_clk) fault_rd = 1'b1;
      @(negedge sys_clk) fault_rd = 1'b0;
      d = fault_rd_data;
    end
  endtask
  // duration write, same one-cycle strobe shape
  task wr(input [1:0] v);
    begin
      @(negedge sys_clk) timer_dur_we = 1'b1;
      timer_dur_wdata = v;
      @(negedge sys_clk) timer_dur_we = 1'b0;
    end
  endtask
endmodule

// ---- tb/cts_top_bench.sv ----
`timescale 1ns/1ps
module cts_top_bench;
  reg sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, charge_en_pin_n = 1'b0;
  reg batt_above_recharge = 1'b0, chg_below_term = 1'b0, batt_below_lowbat = 1'b0;
  reg input_current_regulation = 1'b0, input_voltage_regulation = 1'b0;
  reg thermal_regulation = 1'b0, thermal_shutdown = 1'b0, input_overvoltage = 1'b0;
  reg system_overvoltage = 1'b0, boost_overcurrent = 1'b0, boost_overvoltage = 1'b0;
  reg source_identified = 1'b0, good_input = 1'b0, usb100_source = 1'b0, sleep_mode = 1'b0;
  reg default_mode = 1'b0, term_enable = 1'b1, timer_enable = 1'b1;
  reg reduced_current_bit = 1'b0, half_rate_enable = 1'b1;
  reg [2:0] ntc_fault_in = 3'h0;
  reg [1:0] charge_config = 2'h1, thermal_limit_sel = 2'h0, v;
  reg [7:0] d;
  integer failures = 0, n_tests = 0, cyc = 0, i, n;
  wire fault_rd, timer_dur_we, thermal_reg_status, battery_switch_off, converter_off;
  wire boost_exit, input_high_impedance, reverse_block_switch_on, int_pulse_n, stat_o, stat_oe;
  wire [1:0] timer_dur_wdata, charge_phase, thermal_limit_out, timer_dur_reg;
  wire [7:0] fault_rd_data;
  localparam integer PRE_T = 3 * 20; // precharge limit in cycles at the bench rate
  always #5 sys_clk = ~sys_clk;
  cts_top #(.SEC_CYCLES(27'h14), .INT_CYCLES(15'h8), .HIC_OFF_CYCLES(22'ha),
    .HIC_ON_CYCLES(22'h4), .PRE_SEC(17'h3), .FAST_SEC0(17'h4), .FAST_SEC1(17'h5),
    .FAST_SEC2(17'h6), .FAST_SEC3(17'h7), .USB_SEC(12'h5)) cts_top_inst (.sys_clk, .rst,
    .clk_en, .charge_en_pin_n, .batt_above_recharge, .chg_below_term, .batt_below_lowbat,
    .input_current_regulation, .input_voltage_regulation, .thermal_regulation,
    .thermal_shutdown, .input_overvoltage, .system_overvoltage, .boost_overcurrent,
    .boost_overvoltage, .source_identified, .good_input, .usb100_source, .ntc_fault_in,
    .sleep_mode, .default_mode, .term_enable, .timer_enable, .timer_dur_we, .timer_dur_wdata,
    .charge_config, .reduced_current_bit, .half_rate_enable, .thermal_limit_sel, .fault_rd,
    .fault_rd_data, .charge_phase, .thermal_reg_status, .thermal_limit_out, .timer_dur_reg,
    .battery_switch_off, .converter_off, .boost_exit, .input_high_impedance,
    .reverse_block_switch_on, .int_pulse_n, .stat_o, .stat_oe);
  cts_host_model cts_host_model_inst (.sys_clk, .fault_rd_data, .fault_rd, .timer_dur_we,
    .timer_dur_wdata);
  task chk(input [7:0] s, input [7:0] e);
    begin
      n_tests = n_tests + 1;
      if (s !== e) begin
        failures = failures + 1;
        $display("ERROR t=%0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task complete_run;
    begin
      $display("tests %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // expected fault view: boost bit for the boost sources, category code otherwise
  function [7:0] fexp(input integer k);
    fexp = (k > 1) ? 8'h40 : {2'h0, (k == 0) ? 2'h2 : 2'h1, 4'h0};
  endfunction
  task tk(input integer c);
    repeat (c) @(negedge sys_clk);
  endtask
  // bounded waits on interrupt and phase; the limit counts as a miss
  task wi;
    begin
      n = 0;
      while (int_pulse_n !== 1'b0 && n < 12) begin tk(1); n = n + 1; end
      chk(int_pulse_n, 1'b0);
    end
  endtask
  task wt(input [1:0] p, input integer lim);
    begin
      n = 0;
      while (charge_phase !== p && n < lim) begin tk(1); n = n + 1; end
      chk(charge_phase, p);
    end
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin failures = failures + 1; complete_run; end
  end
  initial begin
    void'($urandom(32'ha0b2));
    tk(4); rst = 1'b0; tk(1);
    chk({int_pulse_n, reverse_block_switch_on, timer_dur_reg}, 8'h0e);
    chk(fault_rd_data, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      v = 2'($urandom);
      cts_host_model_inst.wr(v); chk(timer_dur_reg, v);
    end
    cts_host_model_inst.wr(2'h3);
    $display("test reset and duration done");
    // end of charge held off by regulation and by the enable bit
    wt(2'h2, 20); tk(2); chk(stat_oe, 1'b1);
    {input_current_regulation, input_voltage_regulation, thermal_regulation} = 3'h7;
    thermal_limit_sel = 2'($urandom);
    batt_above_recharge = 1'b1;
    chg_below_term = 1'b1;
    tk(12);
    chk(charge_phase, 2'h2); chk(thermal_reg_status, 1'b1);
    chk(thermal_limit_out, thermal_limit_sel);
    {input_current_regulation, input_voltage_regulation, thermal_regulation} = 3'h0;
    term_enable = 1'b0; tk(12); chk(charge_phase, 2'h2);
    term_enable = 1'b1; wi; chk(charge_phase, 2'h3); chk(battery_switch_off, 1'b1);
    tk(2); chk(stat_oe, 1'b0);
    batt_above_recharge = 1'b0; wt(2'h2, 20);
    // random loop flags: the status bit follows the thermal flag alone
    for (i = 0; i < 6; i = i + 1) begin
      input_current_regulation = 1'($urandom);
      input_voltage_regulation = 1'($urandom);
      thermal_regulation = 1'($urandom);
      tk(6);
      chk(thermal_reg_status, thermal_regulation);
    end
    {input_current_regulation, input_voltage_regulation, thermal_regulation} = 3'h0;
    // sleep drops the charge and releases the status pin
    sleep_mode = 1'b1;
    tk(7);
    chk(stat_oe, 1'b0);
    chk(charge_phase, 2'h0);
    sleep_mode = 1'b0;
    wt(2'h2, 20);
    $display("test termination done");
    for (i = 0; i < 2; i = i + 1) begin
      tk(12);
      source_identified = (i == 0);
      good_input = (i == 1);
      wi;
      // a frozen clock must hold the pulse past its normal length
      if (i == 0) begin
        clk_en = 1'b0;
        tk(20);
        chk(int_pulse_n, 1'b0);
        clk_en = 1'b1;
      end
    end
    // timer disabled so only the low-current cap can stop the converter
    timer_enable = 1'b0; default_mode = 1'b1; usb100_source = 1'b1; tk(130);
    chk(input_high_impedance, 1'b1); chk(converter_off, 1'b1);
    // default mode leaves high-z only once the source is seen gone
    usb100_source = 1'b0;
    tk(8);
    chk(input_high_impedance, 1'b0);
    default_mode = 1'b0;
    tk(4);
    $display("test usb timer done");
    for (i = 0; i < 4; i = i + 1) begin
      cts_host_model_inst.rd(d); cts_host_model_inst.rd(d); tk(12);
      thermal_shutdown = (i == 0);
      input_overvoltage = (i == 1);
      boost_overcurrent = (i == 2);
      boost_overvoltage = (i == 3);
      wi; tk(30);
      if (i < 2) chk(converter_off, 1'b1);
      if (i == 3) chk(boost_exit, 1'b1);
      cts_host_model_inst.rd(d); chk(d, fexp(i));
      {boost_overvoltage, boost_overcurrent, input_overvoltage, thermal_shutdown} = 4'h0;
      tk(30); cts_host_model_inst.rd(d); cts_host_model_inst.rd(d); chk(d, 8'h00);
    end
    ntc_fault_in = 3'h5; wi; tk(10); cts_host_model_inst.rd(d); chk(d, 8'h05);
    ntc_fault_in = 3'h0; tk(12); cts_host_model_inst.rd(d); cts_host_model_inst.rd(d);
    $display("test faults done");
    timer_enable = 1'b1; batt_below_lowbat = 1'b1; charge_config = 2'h0; tk(12);
    charge_config = 2'h1; wt(2'h1, 20);
    wt(2'h0, 400); chk(n <= PRE_T + 30, 1'b1);
    cts_host_model_inst.rd(d); chk(d[5:4], 2'h3);
    reduced_current_bit = 1'b1; timer_enable = 1'b0; tk(2); timer_enable = 1'b1;
    // the first halved tick may land at once, so two doubled gaps are the floor
    wt(2'h1, 20); wt(2'h0, 400); chk(n >= 2 * PRE_T - 40, 1'b1);
    half_rate_enable = 1'b0; charge_en_pin_n = 1'b1; tk(12); charge_en_pin_n = 1'b0;
    wt(2'h1, 20); wt(2'h0, 400); chk(n <= PRE_T + 30, 1'b1);
    $display("test safety timer done");
    complete_run;
  end
endmodule
bind cts_top cts_top_assertions cts_top_assertions_inst (.sys_clk, .rst, .clk_en,
  .timer_dur_we, .timer_dur_wdata, .charge_phase, .timer_dur_reg, .battery_switch_off,
  .converter_off, .input_high_impedance, .reverse_block_switch_on, .int_pulse_n, .stat_o,
  .stat_oe);
